// File: i2sc_defines.svh
// register map, field positions, reset values and timing counts
`ifndef I2SC_DEFINES_SVH
`define I2SC_DEFINES_SVH

`define I2SC_OFS_MAIN 8'h00
`define I2SC_OFS_CU0 8'h04
`define I2SC_OFS_CU1 8'h08
`define I2SC_OFS_SYNC 8'h18
`define I2SC_OFS_SER0 8'h20
`define I2SC_OFS_SER1 8'h24
`define I2SC_OFS_SMP0 8'h30
`define I2SC_OFS_SMP1 8'h34

// main_control bit positions (serializer_on 5:4, clock_unit_on 3:2)
`define I2SC_BIT_SRST 0
`define I2SC_BIT_EN 1
`define I2SC_BIT_CU0 2
`define I2SC_BIT_SER0 4

// clock_unit_control fields
`define I2SC_CU_SW_LSB 0
`define I2SC_CU_SC_LSB 2
`define I2SC_CU_DIV_LSB 19
// serializer_control: clock unit select
`define I2SC_SER_CKSEL 5

// main_control reset, stored bits 5:1
`define I2SC_RST_MAIN 5'h00
`define I2SC_RST_CU 32'h00000000
`define I2SC_RST_SER 32'h00000000
`define I2SC_RST_SMP 32'h00000000

`define I2SC_CLK_NS 4
`define I2SC_SYNC_NS 20
`define I2SC_SYNC_CYC ((`I2SC_SYNC_NS + `I2SC_CLK_NS - 1) / `I2SC_CLK_NS)

`endif

// File: i2sc_pkg.sv
// shared types of the audio serial control block
package i2sc_pkg;
  typedef enum {I2SC_SR_IDLE, I2SC_SR_BUSY} i2sc_srst_st_t;
  typedef logic [5:1] i2sc_en_t;
endpackage

// File: i2sc_buf.sv
// two-entry valid/ready buffer for outgoing sample words
`timescale 1ns/100ps
module i2sc_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("i2sc_buf needs DEPTH >= 2 and WIDTH >= 1");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_r != CW'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : AW'(wp_r + 1'b1);
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : AW'(rp_r + 1'b1);
      end
      if (push && !pop) begin
        cnt_r <= CW'(cnt_r + 1'b1);
      end else if (pop && !push) begin
        cnt_r <= CW'(cnt_r - 1'b1);
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_buf_full_refuse;
    (cnt_r == CW'(DEPTH)) && !pop |=> !in_ready_o;
  endproperty
  a_buf_full_refuse: assert property (p_buf_full_refuse)
    else $error("buffer accepted a word while full");

  property p_buf_count;
    push && !pop |=> cnt_r == CW'($past(cnt_r) + 1'b1);
  endproperty
  a_buf_count: assert property (p_buf_count)
    else $error("buffer count did not follow a push");
endmodule // i2sc_buf

// File: i2sc_ctrl.sv
// control registers, clock units and serializers of the audio serial port
`timescale 1ns/100ps
`include "i2sc_defines.svh"

// Summary of operation
// - bus takes 8, 16, 32-bit accesses
// - each byte lane written independently
// - clock unit words writable only when disabled
// - enable changes pass a synchronising delay
// - bits 5:4 switch serializers on, off
// - bits 3:2 switch clock units on, off
// - bit 1 enables peripheral, reads back state
// - soft reset returns all registers, disables
// - soft reset write drops other written bits
// - soft reset bit reads one while ongoing
// - writing zero to soft reset does nothing
// - busy bit shows pending enable synchronisation
// - bit clock from divider field plus one
// - slot width code picks 8..32 bits
// - slots per frame equal count plus one
module i2sc_ctrl #(
  parameter int SYNC_CYC = `I2SC_SYNC_CYC,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [1:0] sck_o,
  output logic [1:0] fs_o,
  output logic [1:0] sd_o
);
  if (SYNC_CYC < 1 || SYNC_CYC > 255 || BUF_DEPTH < 2) begin : g_chk
    $error("i2sc_ctrl: SYNC_CYC 1..255 and BUF_DEPTH >= 2 required");
  end

  localparam logic [7:0] SYNC_LOAD = 8'(SYNC_CYC - 1);

  function automatic logic [31:0] i2sc_merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [5:0] i2sc_slot_bits(input logic [1:0] code);
    return {code, 3'b000} + 6'h08;
  endfunction

  logic ack_r;
  logic [31:0] dat_r;
  i2sc_pkg::i2sc_en_t main_r;
  i2sc_pkg::i2sc_en_t eff_r;
  i2sc_pkg::i2sc_en_t busy_r;
  i2sc_pkg::i2sc_en_t chg;
  logic [7:0] sync_cnt_r;
  i2sc_pkg::i2sc_srst_st_t srst_st_r;
  logic [7:0] srst_cnt_r;
  logic [31:0] cu_r [2];
  logic [31:0] ser_r [2];
  logic [31:0] smp_r [2];
  logic [7:0] a;
  logic req;
  logic is_main;
  logic [1:0] is_cu;
  logic [1:0] is_ser;
  logic [1:0] is_smp;
  logic [1:0] buf_in_rdy;
  logic [1:0] buf_out_vld;
  logic [31:0] buf_out [2];
  logic [1:0] pop;
  logic rdy_sel;
  logic wr_go;
  logic wr_ok;
  logic mwr;
  logic srst_busy;
  logic srst_wr;
  logic clr;
  logic [31:0] wmain;
  logic [31:0] rdata;
  logic [1:0] cu_act;
  logic [1:0] adv;
  logic [1:0] wrap;
  logic [5:0] sbits [2];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // bus side
  assign a = {wb_adr_i[7:2], 2'b00};
  assign is_main = (a == `I2SC_OFS_MAIN);
  assign is_cu = {a == `I2SC_OFS_CU1, a == `I2SC_OFS_CU0};
  assign is_ser = {a == `I2SC_OFS_SER1, a == `I2SC_OFS_SER0};
  assign is_smp = {a == `I2SC_OFS_SMP1, a == `I2SC_OFS_SMP0};
  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  // a sample write waits for room in its buffer
  assign rdy_sel = ~|(is_smp & ~buf_in_rdy);
  assign wr_go = req & wb_we_i & rdy_sel;
  assign srst_busy = (srst_st_r == i2sc_pkg::I2SC_SR_BUSY);
  assign srst_wr = wr_go & is_main & wb_sel_i[0] &
    wb_dat_i[`I2SC_BIT_SRST] & ~srst_busy;
  assign wr_ok = wr_go & ~srst_busy;
  assign mwr = wr_ok & is_main & ~srst_wr;
  assign clr = srst_busy & (srst_cnt_r == 8'h00);
  assign wmain = i2sc_merge({26'h0, main_r, 1'b0}, wb_dat_i, wb_sel_i);
  assign chg = wmain[5:1] ^ main_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & (~wb_we_i | rdy_sel);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= '0;
    end else if (req && !wb_we_i) begin
      dat_r <= rdata;
    end
  end

  always_comb begin
    rdata = '0;
    case (a)
      `I2SC_OFS_MAIN: rdata = {26'h0, main_r, srst_busy};
      `I2SC_OFS_SYNC: rdata = {26'h0, busy_r, srst_busy};
      `I2SC_OFS_CU0: rdata = cu_r[0];
      `I2SC_OFS_CU1: rdata = cu_r[1];
      `I2SC_OFS_SER0: rdata = ser_r[0];
      `I2SC_OFS_SER1: rdata = ser_r[1];
      `I2SC_OFS_SMP0: rdata = smp_r[0];
      `I2SC_OFS_SMP1: rdata = smp_r[1];
      default: rdata = '0;
    endcase
  end

  // enable bits; the soft reset bit itself is never stored
  always_ff @(posedge clk_i) begin
    if (rst_i || clr) begin
      main_r <= `I2SC_RST_MAIN;
    end else if (mwr) begin
      main_r <= wmain[5:1];
    end
  end

  // enable changes reach the serial logic only after the sync delay
  always_ff @(posedge clk_i) begin
    if (rst_i || clr) begin
      busy_r <= '0;
      eff_r <= '0;
      sync_cnt_r <= 8'h00;
    end else if (mwr && chg != '0) begin
      busy_r <= busy_r | chg;
      sync_cnt_r <= SYNC_LOAD;
    end else if (sync_cnt_r != 8'h00) begin
      sync_cnt_r <= sync_cnt_r - 8'h01;
    end else if (busy_r != '0) begin
      busy_r <= '0;
      eff_r <= main_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      srst_st_r <= i2sc_pkg::I2SC_SR_IDLE;
      srst_cnt_r <= 8'h00;
    end else begin
      case (srst_st_r)
        i2sc_pkg::I2SC_SR_IDLE: begin
          if (srst_wr) begin
            srst_st_r <= i2sc_pkg::I2SC_SR_BUSY;
            srst_cnt_r <= SYNC_LOAD;
          end
        end
        i2sc_pkg::I2SC_SR_BUSY: begin
          if (srst_cnt_r != 8'h00) begin
            srst_cnt_r <= srst_cnt_r - 8'h01;
          end else begin
            srst_st_r <= i2sc_pkg::I2SC_SR_IDLE;
          end
        end
        default: srst_st_r <= i2sc_pkg::I2SC_SR_IDLE;
      endcase
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_unit
    logic [4:0] div_cnt_r;
    logic [5:0] bit_r;
    logic [2:0] slot_r;
    logic [2:0] slot_nxt;
    logic sck_r;
    logic fs_r;
    logic tick;
    logic lastbit;
    logic [4:0] div;
    logic [2:0] nsl;

    always_ff @(posedge clk_i) begin
      if (rst_i || clr) begin
        cu_r[i] <= `I2SC_RST_CU;
      end else if (wr_ok && is_cu[i] && !main_r[`I2SC_BIT_EN]) begin
        cu_r[i] <= i2sc_merge(cu_r[i], wb_dat_i, wb_sel_i);
      end
    end

    assign div = cu_r[i][`I2SC_CU_DIV_LSB +: 5];
    assign nsl = cu_r[i][`I2SC_CU_SC_LSB +: 3];
    assign sbits[i] = i2sc_slot_bits(cu_r[i][`I2SC_CU_SW_LSB +: 2]);
    // clock units run only with the module enabled
    assign cu_act[i] = eff_r[`I2SC_BIT_EN] & eff_r[`I2SC_BIT_CU0 + i] &
      ~srst_busy;
    assign tick = (div_cnt_r == div);
    assign adv[i] = cu_act[i] & tick & sck_r;
    assign lastbit = (bit_r == sbits[i] - 6'h01);
    assign wrap[i] = adv[i] & lastbit & (slot_r == nsl);
    assign slot_nxt = (adv[i] && lastbit) ?
      ((slot_r == nsl) ? 3'h0 : 3'(slot_r + 1'b1)) : slot_r;
    assign sck_o[i] = sck_r;
    assign fs_o[i] = fs_r;

    always_ff @(posedge clk_i) begin
      if (rst_i || !cu_act[i]) begin
        div_cnt_r <= 5'h00;
        sck_r <= 1'b0;
        bit_r <= 6'h00;
        slot_r <= 3'h0;
        fs_r <= 1'b0;
      end else begin
        div_cnt_r <= tick ? 5'h00 : 5'(div_cnt_r + 1'b1);
        if (tick) begin
          sck_r <= ~sck_r;
        end
        if (adv[i]) begin
          bit_r <= lastbit ? 6'h00 : 6'(bit_r + 1'b1);
        end
        slot_r <= slot_nxt;
        fs_r <= (slot_nxt == 3'h0);
      end
    end

    property p_div_hold;
      cu_act[i] && !tick |=> sck_r == $past(sck_r);
    endproperty
    a_div_hold: assert property (p_div_hold)
      else $error("serial clock moved before divider count ended");

    property p_slot_bits;
      cu_act[i] && $stable(cu_r[i]) |-> bit_r < sbits[i];
    endproperty
    a_slot_bits: assert property (p_slot_bits)
      else $error("bit index beyond programmed slot width");

    property p_slot_count;
      wrap[i] |=> slot_r == 3'h0 && fs_r;
    endproperty
    a_slot_count: assert property (p_slot_count)
      else $error("frame did not restart after last slot");
  end

  for (genvar j = 0; j < 2; j++) begin : g_ser
    logic cs;
    logic sact;
    logic [31:0] sh_r;

    always_ff @(posedge clk_i) begin
      if (rst_i || clr) begin
        ser_r[j] <= `I2SC_RST_SER;
      end else if (wr_ok && is_ser[j]) begin
        ser_r[j] <= i2sc_merge(ser_r[j], wb_dat_i, wb_sel_i);
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i || clr) begin
        smp_r[j] <= `I2SC_RST_SMP;
      end else if (wr_ok && is_smp[j]) begin
        smp_r[j] <= i2sc_merge(smp_r[j], wb_dat_i, wb_sel_i);
      end
    end

    i2sc_buf #(
      .WIDTH(32),
      .DEPTH(BUF_DEPTH)
    ) u_buf (
      .clk_i(clk_i),
      .rst_i(rst_i | clr),
      .in_valid_i(wr_ok & is_smp[j]),
      .in_ready_o(buf_in_rdy[j]),
      .in_data_i(i2sc_merge(smp_r[j], wb_dat_i, wb_sel_i)),
      .out_valid_o(buf_out_vld[j]),
      .out_ready_i(pop[j]),
      .out_data_o(buf_out[j])
    );

    assign cs = ser_r[j][`I2SC_SER_CKSEL];
    assign sact = eff_r[`I2SC_BIT_EN] & eff_r[`I2SC_BIT_SER0 + j] &
      cu_act[cs];
    // one word leaves the buffer per frame, at the frame boundary
    assign pop[j] = sact & wrap[cs];
    assign sd_o[j] = sh_r[31];

    always_ff @(posedge clk_i) begin
      if (rst_i || !sact) begin
        sh_r <= 32'h00000000;
      end else if (wrap[cs]) begin
        sh_r <= buf_out_vld[j] ?
          (buf_out[j] << (6'h20 - sbits[cs])) : 32'h00000000;
      end else if (adv[cs]) begin
        sh_r <= {sh_r[30:0], 1'b0};
      end
    end
  end

  property p_ack_pulse;
    wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i |=> ack_r ##1 !ack_r;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("read not answered as a single ack pulse");

  property p_lane_keep;
    wr_ok && is_cu[0] && !main_r[`I2SC_BIT_EN] && wb_sel_i == 4'h1
      |=> cu_r[0][31:8] == $past(cu_r[0][31:8]);
  endproperty
  a_lane_keep: assert property (p_lane_keep)
    else $error("byte write disturbed other lanes");

  property p_protect;
    wr_ok && is_cu[1] && main_r[`I2SC_BIT_EN] |=> $stable(cu_r[1]);
  endproperty
  a_protect: assert property (p_protect)
    else $error("clock unit word changed while enabled");

  property p_sync_done;
    busy_r != '0 && sync_cnt_r == 8'h00 && !mwr && !clr
      |=> busy_r == '0 && eff_r == $past(main_r);
  endproperty
  a_sync_done: assert property (p_sync_done)
    else $error("enable change not applied after sync delay");

  property p_ser_on;
    mwr && wb_sel_i[0] && wb_dat_i[`I2SC_BIT_SER0] |=> main_r[4];
  endproperty
  a_ser_on: assert property (p_ser_on)
    else $error("serializer enable write lost");

  property p_cu_off;
    mwr && wb_sel_i[0] && !wb_dat_i[`I2SC_BIT_CU0 + 1] |=> !main_r[3];
  endproperty
  a_cu_off: assert property (p_cu_off)
    else $error("clock unit disable write lost");

  property p_en_read;
    req && !wb_we_i && is_main |=> dat_r[1] == $past(main_r[1]);
  endproperty
  a_en_read: assert property (p_en_read)
    else $error("enable bit read back wrong");

  property p_srst_clear;
    clr |=> main_r == '0 && cu_r[0] == '0 && smp_r[1] == '0 && !srst_busy;
  endproperty
  a_srst_clear: assert property (p_srst_clear)
    else $error("soft reset left a register set");

  property p_srst_discard;
    srst_wr |=> $stable(main_r) && srst_busy;
  endproperty
  a_srst_discard: assert property (p_srst_discard)
    else $error("bits written with soft reset took effect");

  property p_srst_read;
    srst_busy && req && !wb_we_i && is_main |=> dat_r[0];
  endproperty
  a_srst_read: assert property (p_srst_read)
    else $error("soft reset bit read zero while ongoing");

  property p_srst_zero;
    !srst_busy && wr_go && is_main && !wb_dat_i[0] |=> !srst_busy;
  endproperty
  a_srst_zero: assert property (p_srst_zero)
    else $error("writing zero started a soft reset");

  property p_busy_set;
    mwr && chg[`I2SC_BIT_SER0] |=> busy_r[`I2SC_BIT_SER0];
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("busy bit not set for pending change");

  property p_gate;
    !eff_r[`I2SC_BIT_EN] |=> sck_o == 2'b00 && sd_o == 2'b00 && fs_o == 2'b00;
  endproperty
  a_gate: assert property (p_gate)
    else $error("serial activity while module disabled");

  c_srst: cover property (srst_wr ##[1:20] clr);
  c_smp_stall: cover property (req && wb_we_i && !rdy_sel);
  c_frame: cover property (pop[0] && buf_out_vld[0]);
endmodule // i2sc_ctrl

// File: i2sc_codec_model.sv
// receiving codec model on one serial channel
`timescale 1ns/100ps
module i2sc_codec_model (
  input wire logic sck_i,
  input wire logic fs_i,
  input wire logic sd_i,
  output logic [31:0] word_o,
  output int frames_o
);
  logic [31:0] shift_r;
  logic fs_r;

  initial begin
    shift_r = 32'h00000000;
    fs_r = 1'b0;
    word_o = 32'h00000000;
    frames_o = 0;
  end

  // data is stable at the rising serial clock edge
  always @(posedge sck_i) begin
    fs_r <= fs_i;
    if (fs_i && !fs_r) begin
      shift_r <= {31'h00000000, sd_i};
    end else if (fs_i) begin
      shift_r <= {shift_r[30:0], sd_i};
    end
    // slot 0 complete once frame sync drops
    if (!fs_i && fs_r) begin
      word_o <= shift_r;
      frames_o <= frames_o + 1;
    end
  end
endmodule // i2sc_codec_model

// File: test_i2sc_ctrl.sv
// self-checking bench of the audio serial control block
`timescale 1ns/100ps
`include "i2sc_defines.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end

module test_i2sc_ctrl;
  localparam int SYNC = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h00000000, dat_o, rdat, w;
  logic ack;
  logic [1:0] sck_o, fs_o, sd_o;
  logic [31:0] word;
  int frames, num_errors = 0, check_count = 0, cycles = 0, r, c, n;
  logic [7:0] rst_adr [6] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h20, 8'h24};

  always #2 clk_i = ~clk_i;

  i2sc_ctrl #(.SYNC_CYC(SYNC), .BUF_DEPTH(2)) i_i2sc_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .sck_o(sck_o), .fs_o(fs_o),
    .sd_o(sd_o));

  i2sc_codec_model i_i2sc_codec_model (.sck_i(sck_o[0]), .fs_i(fs_o[0]),
    .sd_i(sd_o[0]), .word_o(word), .frames_o(frames));

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      stop_test();
    end
  end

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic wr, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    sel <= s;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, 4'hF, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 4'hF, 32'h00000000);
    `CHK(rdat, e)
  endtask

  // one full frame: serial clock rises and clk cycles between fs rises
  task automatic frame(output int rises, output int clks);
    logic ps, pf;
    // the first frame after enabling is one clock short, so skip it
    repeat (2) begin
      pf = 1'b1;
      do begin
        pf = fs_o[0];
        @(negedge clk_i);
      end while (!(fs_o[0] === 1'b1 && pf === 1'b0));
    end
    rises = 0;
    clks = 0;
    ps = sck_o[0];
    pf = 1'b1;
    do begin
      pf = fs_o[0];
      @(negedge clk_i);
      clks++;
      if (sck_o[0] === 1'b1 && ps === 1'b0) rises++;
      ps = sck_o[0];
    end while (!(fs_o[0] === 1'b1 && pf === 1'b0));
  endtask

  task automatic count_sck(output int c0, output int c1);
    logic [1:0] p;
    p = sck_o;
    c0 = 0;
    c1 = 0;
    repeat (200) begin
      @(negedge clk_i);
      if (sck_o[0] && !p[0]) c0++;
      if (sck_o[1] && !p[1]) c1++;
      p = sck_o;
    end
  endtask

  task automatic next_word(output logic [31:0] v);
    int f;
    f = frames;
    while (frames == f) @(negedge clk_i);
    v = word;
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rst_adr[i]) rd(rst_adr[i], 32'h00000000);
    wr(`I2SC_OFS_CU0, 32'h11223344);
    wb(1'b1, `I2SC_OFS_CU0, 4'b0010, 32'h0000AA00);
    wb(1'b1, `I2SC_OFS_CU0, 4'b1100, 32'h55660000);
    wb(1'b1, `I2SC_OFS_CU0, 4'b0001, 32'h000000FF);
    rd(`I2SC_OFS_CU0, 32'h5566AAFF);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h00000000);
    wr(`I2SC_OFS_MAIN, 32'h00000002);
    rd(`I2SC_OFS_SYNC, 32'h00000002);
    repeat (10) @(posedge clk_i);
    rd(`I2SC_OFS_SYNC, 32'h00000000);
    rd(`I2SC_OFS_MAIN, 32'h00000002);
    wr(`I2SC_OFS_CU0, 32'h00000000);
    rd(`I2SC_OFS_CU0, 32'h5566AAFF);
    wr(`I2SC_OFS_CU1, 32'hFFFFFFFF);
    rd(`I2SC_OFS_CU1, 32'h00000000);
    wr(`I2SC_OFS_MAIN, 32'h00000000);
    wr(`I2SC_OFS_CU0, 32'h00180004);
    wr(`I2SC_OFS_MAIN, 32'h0000003C);
    count_sck(r, c);
    `CHK(r + c, 0)
    `CHK(sck_o, 2'b00)
    `CHK(fs_o, 2'b00)
    `CHK(sd_o, 2'b00)
    wr(`I2SC_OFS_MAIN, 32'h0000000A);
    repeat (10) @(posedge clk_i);
    count_sck(r, c);
    `CHK(r, 0)
    `CHK(c > 0, 1'b1)
    for (int code = 0; code < 4; code++) begin
      wr(`I2SC_OFS_MAIN, 32'h00000000);
      wr(`I2SC_OFS_CU0, 32'h00180004 | code);
      wr(`I2SC_OFS_MAIN, 32'h00000016);
      frame(r, c);
      `CHK(c, r * 8)
      `CHK(r, 16 * (code + 1))
    end
    wr(`I2SC_OFS_MAIN, 32'h00000000);
    wr(`I2SC_OFS_CU0, 32'h00180004);
    wr(`I2SC_OFS_SER0, 32'h00000000);
    wr(`I2SC_OFS_MAIN, 32'h00000016);
    // third word waits until a frame end pops one word from the buffer
    wr(`I2SC_OFS_SMP0, 32'hFFFFFF11);
    wr(`I2SC_OFS_SMP0, 32'h00000022);
    wr(`I2SC_OFS_SMP0, 32'h00000033);
    w = 32'h00000000;
    n = 0;
    while (w !== 32'h00000011 && n < 6) begin
      next_word(w);
      n++;
    end
    `CHK(w, 32'h00000011)
    next_word(w);
    `CHK(w, 32'h00000022)
    next_word(w);
    `CHK(w, 32'h00000033)
    // single clock domain, so it is always running before the reset
    wr(`I2SC_OFS_MAIN, 32'h0000003F);
    // enables stay as they were until the reset completes
    rd(`I2SC_OFS_MAIN, 32'h00000017);
    repeat (12) @(posedge clk_i);
    rd(`I2SC_OFS_MAIN, 32'h00000000);
    rd(`I2SC_OFS_CU0, 32'h00000000);
    rd(`I2SC_OFS_SYNC, 32'h00000000);
    wr(`I2SC_OFS_CU0, 32'h00000012);
    wr(`I2SC_OFS_MAIN, 32'h00000000);
    rd(`I2SC_OFS_MAIN, 32'h00000000);
    repeat (12) @(posedge clk_i);
    rd(`I2SC_OFS_CU0, 32'h00000012);
    stop_test();
  end
endmodule // test_i2sc_ctrl
